// ===== verilog/frontend_cfg_pkg.sv
// Constants for the receive-gain and emitter-drive configuration registers
package frontend_cfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] RECEIVE_GAIN_CONFIG_ADDR = 8'h21;
  localparam logic [7:0] EMITTER_DRIVE_CONFIG_ADDR = 8'h22;
  localparam int REG_WIDTH = 24;
  localparam int ADDR_WIDTH = 8;
  localparam int FRAME_BITS = 32;
  localparam logic [23:0] RECEIVE_GAIN_CONFIG_RESET = 24'h000000;
  localparam logic [23:0] EMITTER_DRIVE_CONFIG_RESET = 24'h000000;

  // ==========================================================
  // Receive-gain fields
  localparam int AMBIENT_CANCEL_LSB = 16;
  localparam int AMBIENT_CANCEL_MSB = 19;
  localparam int FILTER_CORNER_BIT = 15;
  localparam int SECOND_STAGE_ENABLE_BIT = 14;
  localparam int SECOND_STAGE_GAIN_LSB = 8;
  localparam int SECOND_STAGE_GAIN_MSB = 10;
  localparam int FEEDBACK_CAP_LSB = 3;
  localparam int FEEDBACK_CAP_MSB = 7;
  localparam int FEEDBACK_RES_LSB = 0;
  localparam int FEEDBACK_RES_MSB = 2;

  // ==========================================================
  // Emitter-drive fields
  localparam int RANGE_LSB = 16;
  localparam int RANGE_MSB = 17;
  localparam int FIRST_CODE_LSB = 8;
  localparam int FIRST_CODE_MSB = 15;
  localparam int SECOND_CODE_LSB = 0;
  localparam int SECOND_CODE_MSB = 7;

  // ==========================================================
  // Full-scale current in mA per range and transmit reference
  localparam logic [6:0] FULLSCALE_25_MA = 7'h19;
  localparam logic [6:0] FULLSCALE_50_MA = 7'h32;
  localparam logic [6:0] FULLSCALE_75_MA = 7'h4B;
  localparam logic [6:0] FULLSCALE_100_MA = 7'h64;
  localparam logic [6:0] FULLSCALE_OFF_MA = 7'h00;
  localparam logic [9:0] UA_PER_MA = 10'h3E8;
  localparam int CODE_SHIFT = 8;
  localparam int CURRENT_WIDTH = 17;

  // Transmit reference encodings
  localparam logic [1:0] TX_REF_0P25 = 2'h0;
  localparam logic [1:0] TX_REF_0P5 = 2'h1;
  localparam logic [1:0] TX_REF_1P0 = 2'h2;
  localparam logic [1:0] TX_REF_0P75 = 2'h3;

  // Range encodings
  localparam logic [1:0] RANGE_LOW_A = 2'h0;
  localparam logic [1:0] RANGE_WIDE = 2'h1;
  localparam logic [1:0] RANGE_LOW_B = 2'h2;
  localparam logic [1:0] RANGE_TX_OFF = 2'h3;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_ADDR = 2'b01,
    SER_DATA = 2'b10
  } serial_state_type;

endpackage

// ===== verilog/emitter_current_scale.sv
// Nominal emitter current from drive code, range and transmit reference
module emitter_current_scale (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [1:0] range_i,
  input wire logic [1:0] tx_ref_i,
  input wire logic [7:0] code_i,
  output logic [16:0] current_ua_o
);

  logic [6:0] fullscale_ma;
  logic [6:0] low_range_ma;
  logic [6:0] wide_range_ma;
  logic [24:0] product;
  logic [16:0] current_ua_nxt;

  // Reference settings marked unusable on the narrow ranges give no drive
  assign low_range_ma = (tx_ref_i == frontend_cfg_pkg::TX_REF_0P25) ? frontend_cfg_pkg::FULLSCALE_50_MA :
                        (tx_ref_i == frontend_cfg_pkg::TX_REF_0P5) ? frontend_cfg_pkg::FULLSCALE_100_MA :
                        frontend_cfg_pkg::FULLSCALE_OFF_MA;
  assign wide_range_ma = (tx_ref_i == frontend_cfg_pkg::TX_REF_0P25) ? frontend_cfg_pkg::FULLSCALE_25_MA :
                         (tx_ref_i == frontend_cfg_pkg::TX_REF_0P5) ? frontend_cfg_pkg::FULLSCALE_50_MA :
                         (tx_ref_i == frontend_cfg_pkg::TX_REF_0P75) ? frontend_cfg_pkg::FULLSCALE_75_MA :
                         frontend_cfg_pkg::FULLSCALE_100_MA;
  assign fullscale_ma = (range_i == frontend_cfg_pkg::RANGE_WIDE) ? wide_range_ma :
                        (range_i == frontend_cfg_pkg::RANGE_TX_OFF) ? frontend_cfg_pkg::FULLSCALE_OFF_MA :
                        low_range_ma;
  assign product = code_i * fullscale_ma * frontend_cfg_pkg::UA_PER_MA;
  assign current_ua_nxt = product[frontend_cfg_pkg::CODE_SHIFT +: frontend_cfg_pkg::CURRENT_WIDTH];

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      current_ua_o <= 17'h00000;
    end else begin
      current_ua_o <= current_ua_nxt;
    end
  end

endmodule

// ===== verilog/frontend_gain_led_config_regs.sv
// Serial-port register bank for receive-gain and emitter-drive configuration
module frontend_gain_led_config_regs (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic serial_clk_i,
  input wire logic serial_select_n_i,
  input wire logic serial_data_i,
  input wire logic read_enable_i,
  input wire logic [1:0] tx_ref_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  output logic [3:0] ambient_cancel_current_o,
  output logic filter_corner_select_o,
  output logic second_stage_enable_b_o,
  output logic [2:0] second_stage_gain_b_o,
  output logic [4:0] feedback_cap_select_o,
  output logic [2:0] feedback_res_select_o,
  output logic [1:0] drive_fullscale_range_o,
  output logic [7:0] first_emitter_drive_code_o,
  output logic [7:0] second_emitter_drive_code_o,
  output logic [16:0] first_emitter_current_ua_o,
  output logic [16:0] second_emitter_current_ua_o
);

  // ==========================================================
  // Serial frame state
  frontend_cfg_pkg::serial_state_type state_r, state_nxt;
  logic sclk_prev_r;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [23:0] shift_in_r, shift_in_nxt;
  logic [23:0] shift_out_r, shift_out_nxt;
  logic read_mode_r, read_mode_nxt;
  logic serial_data_nxt;
  logic serial_data_oe_nxt;
  logic [23:0] receive_gain_config_r, receive_gain_config_nxt;
  logic [23:0] emitter_drive_config_r, emitter_drive_config_nxt;

  wire sclk_rise = serial_clk_i & ~sclk_prev_r;
  wire sclk_fall = ~serial_clk_i & sclk_prev_r;
  wire selected = ~serial_select_n_i;
  wire last_addr_bit = (bit_cnt_r == 5'(frontend_cfg_pkg::ADDR_WIDTH - 1));
  wire last_frame_bit = (bit_cnt_r == 5'(frontend_cfg_pkg::FRAME_BITS - 1));
  wire [7:0] addr_full = {addr_r[6:0], serial_data_i};
  wire [23:0] data_full = {shift_in_r[22:0], serial_data_i};
  wire write_done = (state_r == frontend_cfg_pkg::SER_DATA) && selected && sclk_rise && last_frame_bit
                    && !read_mode_r;
  wire hit_gain_wr = write_done && (addr_r == frontend_cfg_pkg::RECEIVE_GAIN_CONFIG_ADDR);
  wire hit_drive_wr = write_done && (addr_r == frontend_cfg_pkg::EMITTER_DRIVE_CONFIG_ADDR);

  // Unmapped addresses read as zero
  wire [23:0] read_word = (addr_full == frontend_cfg_pkg::RECEIVE_GAIN_CONFIG_ADDR) ? receive_gain_config_r :
                          (addr_full == frontend_cfg_pkg::EMITTER_DRIVE_CONFIG_ADDR) ? emitter_drive_config_r :
                          24'h000000;

  // ==========================================================
  // Frame sequencer: 8 address bits then 24 data bits, MSB first
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    addr_nxt = addr_r;
    shift_in_nxt = shift_in_r;
    shift_out_nxt = shift_out_r;
    read_mode_nxt = read_mode_r;
    serial_data_nxt = serial_data_o;
    serial_data_oe_nxt = selected && read_mode_r && (state_r == frontend_cfg_pkg::SER_DATA);
    if (!selected) begin
      state_nxt = frontend_cfg_pkg::SER_ADDR;
      bit_cnt_nxt = 5'h00;
      serial_data_nxt = 1'b0;
    end else begin
      case (state_r)
        frontend_cfg_pkg::SER_IDLE: begin
          // Full 32-bit frame done or invalid state; ignore further clocks until deselect
        end
        frontend_cfg_pkg::SER_ADDR: begin
          if (sclk_rise) begin
            addr_nxt = addr_full;
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (last_addr_bit) begin
              state_nxt = frontend_cfg_pkg::SER_DATA;
              read_mode_nxt = read_enable_i;
              shift_out_nxt = read_word;
            end
          end
        end
        frontend_cfg_pkg::SER_DATA: begin
          if (sclk_rise) begin
            shift_in_nxt = data_full;
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (last_frame_bit) begin
              state_nxt = frontend_cfg_pkg::SER_IDLE;
            end
          end
          if (sclk_fall && read_mode_r) begin
            serial_data_nxt = shift_out_r[23];
            shift_out_nxt = {shift_out_r[22:0], 1'b0};
          end
        end
        default: begin
          state_nxt = frontend_cfg_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Register storage; values are kept exactly as written
  // Reserved and forbidden codes are the host's duty and are not filtered
  assign receive_gain_config_nxt = hit_gain_wr ? data_full : receive_gain_config_r;
  assign emitter_drive_config_nxt = hit_drive_wr ? data_full : emitter_drive_config_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= frontend_cfg_pkg::SER_ADDR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Previous serial clock level; resets to the idle low level so no false edge follows reset
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= serial_clk_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= 5'h00;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_r <= 8'h00;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_in_r <= 24'h000000;
    end else begin
      shift_in_r <= shift_in_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_out_r <= 24'h000000;
    end else begin
      shift_out_r <= shift_out_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      read_mode_r <= 1'b0;
    end else begin
      read_mode_r <= read_mode_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_data_o <= 1'b0;
    end else begin
      serial_data_o <= serial_data_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_data_oe_o <= 1'b0;
    end else begin
      serial_data_oe_o <= serial_data_oe_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_gain_config_r <= frontend_cfg_pkg::RECEIVE_GAIN_CONFIG_RESET;
      emitter_drive_config_r <= frontend_cfg_pkg::EMITTER_DRIVE_CONFIG_RESET;
    end else begin
      receive_gain_config_r <= receive_gain_config_nxt;
      emitter_drive_config_r <= emitter_drive_config_nxt;
    end
  end

  // ==========================================================
  // Analog control fields, straight from the stored registers
  assign ambient_cancel_current_o =
    receive_gain_config_r[frontend_cfg_pkg::AMBIENT_CANCEL_MSB:frontend_cfg_pkg::AMBIENT_CANCEL_LSB];
  assign filter_corner_select_o = receive_gain_config_r[frontend_cfg_pkg::FILTER_CORNER_BIT];
  assign second_stage_enable_b_o = receive_gain_config_r[frontend_cfg_pkg::SECOND_STAGE_ENABLE_BIT];
  assign second_stage_gain_b_o =
    receive_gain_config_r[frontend_cfg_pkg::SECOND_STAGE_GAIN_MSB:frontend_cfg_pkg::SECOND_STAGE_GAIN_LSB];
  assign feedback_cap_select_o =
    receive_gain_config_r[frontend_cfg_pkg::FEEDBACK_CAP_MSB:frontend_cfg_pkg::FEEDBACK_CAP_LSB];
  assign feedback_res_select_o =
    receive_gain_config_r[frontend_cfg_pkg::FEEDBACK_RES_MSB:frontend_cfg_pkg::FEEDBACK_RES_LSB];
  assign drive_fullscale_range_o =
    emitter_drive_config_r[frontend_cfg_pkg::RANGE_MSB:frontend_cfg_pkg::RANGE_LSB];
  assign first_emitter_drive_code_o =
    emitter_drive_config_r[frontend_cfg_pkg::FIRST_CODE_MSB:frontend_cfg_pkg::FIRST_CODE_LSB];
  assign second_emitter_drive_code_o =
    emitter_drive_config_r[frontend_cfg_pkg::SECOND_CODE_MSB:frontend_cfg_pkg::SECOND_CODE_LSB];

  // ==========================================================
  // Nominal drive current per emitter; index 0 is the first emitter
  wire [7:0] emitter_code [2];
  wire [16:0] emitter_current_ua [2];
  assign emitter_code[0] = first_emitter_drive_code_o;
  assign emitter_code[1] = second_emitter_drive_code_o;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_emitter_scale
      emitter_current_scale emitter_current_scale_inst (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .range_i(drive_fullscale_range_o),
        .tx_ref_i(tx_ref_i),
        .code_i(emitter_code[ch]),
        .current_ua_o(emitter_current_ua[ch])
      );
    end
  endgenerate

  assign first_emitter_current_ua_o = emitter_current_ua[0];
  assign second_emitter_current_ua_o = emitter_current_ua[1];

endmodule

// ===== bench/frontend_cfg_chk.sv
// Port-level checks on the configuration register bank
module frontend_cfg_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic serial_select_n_i,
  input wire logic [1:0] tx_ref_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe_o,
  input wire logic [3:0] ambient_cancel_current_o,
  input wire logic second_stage_enable_b_o,
  input wire logic [2:0] second_stage_gain_b_o,
  input wire logic [4:0] feedback_cap_select_o,
  input wire logic [1:0] drive_fullscale_range_o,
  input wire logic [7:0] first_emitter_drive_code_o,
  input wire logic [7:0] second_emitter_drive_code_o,
  input wire logic [16:0] first_emitter_current_ua_o,
  input wire logic [16:0] second_emitter_current_ua_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Expected currents
  function automatic int fs_ma(logic [1:0] rg, logic [1:0] rf);
    if (rg == 2'h3) return 0;
    if (rg == 2'h1) return (rf == 2'h0) ? 25 : (rf == 2'h1) ? 50 : (rf == 2'h3) ? 75 : 100;
    return (rf == 2'h0) ? 50 : (rf == 2'h1) ? 100 : 0;
  endfunction
  wire [31:0] fs_now = 32'(fs_ma(drive_fullscale_range_o, tx_ref_i));
  wire [16:0] exp_first = 17'((32'(first_emitter_drive_code_o) * fs_now * 32'd1000) / 32'd256);
  wire [16:0] exp_second = 17'((32'(second_emitter_drive_code_o) * fs_now * 32'd1000) / 32'd256);
  wire [12:0] rx_fields = {ambient_cancel_current_o, second_stage_enable_b_o, second_stage_gain_b_o,
    feedback_cap_select_o};
  wire [17:0] em_fields = {drive_fullscale_range_o, first_emitter_drive_code_o, second_emitter_drive_code_o};
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_idle;
    serial_select_n_i [*3];
  endsequence
  property p_rst_rx; $rose(nrst_i) |-> rx_fields == 13'h0000; endproperty
  property p_rst_em; $rose(nrst_i) |-> em_fields == 18'h00000; endproperty
  property p_hold_rx; s_idle |-> $stable(rx_fields); endproperty
  property p_hold_em; s_idle |-> $stable(em_fields); endproperty
  property p_cur1; first_emitter_current_ua_o == $past(exp_first); endproperty
  property p_cur2; second_emitter_current_ua_o == $past(exp_second); endproperty
  property p_oe_idle; s_idle |-> !serial_data_oe_o; endproperty
  property p_dout_idle; s_idle |-> !serial_data_o; endproperty
  a_rst_rx: assert property (p_rst_rx) else $error("receive fields not zero after reset");
  a_rst_em: assert property (p_rst_em) else $error("emitter fields not zero after reset");
  a_hold_rx: assert property (p_hold_rx) else $error("receive fields moved while idle");
  a_hold_em: assert property (p_hold_em) else $error("emitter fields moved while idle");
  a_cur1: assert property (p_cur1) else $error("first emitter current wrong");
  a_cur2: assert property (p_cur2) else $error("second emitter current wrong");
  a_oe_idle: assert property (p_oe_idle) else $error("output enable high while deselected");
  a_dout_idle: assert property (p_dout_idle) else $error("serial output high while deselected");
endmodule

bind frontend_gain_led_config_regs frontend_cfg_chk frontend_cfg_chk_inst (
  .clock_i(clock_i), .nrst_i(nrst_i), .serial_select_n_i(serial_select_n_i), .tx_ref_i(tx_ref_i),
  .serial_data_o(serial_data_o), .serial_data_oe_o(serial_data_oe_o),
  .ambient_cancel_current_o(ambient_cancel_current_o), .second_stage_enable_b_o(second_stage_enable_b_o),
  .second_stage_gain_b_o(second_stage_gain_b_o), .feedback_cap_select_o(feedback_cap_select_o),
  .drive_fullscale_range_o(drive_fullscale_range_o), .first_emitter_drive_code_o(first_emitter_drive_code_o),
  .second_emitter_drive_code_o(second_emitter_drive_code_o),
  .first_emitter_current_ua_o(first_emitter_current_ua_o),
  .second_emitter_current_ua_o(second_emitter_current_ua_o)
);

// ===== bench/serial_host_model.sv
// Host-side serial master that frames register writes and reads
module serial_host_model (
  input wire logic clock_i,
  input wire logic data_i,
  output logic serial_clk_o,
  output logic select_n_o,
  output logic data_o,
  output logic read_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk_o = 1'b0;
    select_n_o = 1'b1;
    data_o = 1'b0;
    read_enable_o = 1'b0;
  end
  // One frame: 8 address bits then 24 data bits, clock low and high two cycles each
  task automatic frame(input logic [7:0] a, input logic r, input logic [23:0] w, output logic [23:0] q);
    logic [31:0] sh;
    sh = {a, w};
    q = 24'h000000;
    read_enable_o = r;
    select_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      data_o = sh[i];
      repeat (2) @(posedge clock_i);
      #1;
      if (i < 24) q[i] = data_i;
      serial_clk_o = 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      serial_clk_o = 1'b0;
    end
    repeat (2) @(posedge clock_i);
    #1;
    select_n_o = 1'b1;
    // Released line must not keep its last level
    data_o = ~data_o;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the configuration register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] tx_ref = 2'h0;
  logic sclk, sel_n, sdi, rd_en, sdo, sdo_oe, filt, en_b;
  logic [3:0] amb;
  logic [2:0] gain, res;
  logic [4:0] cap;
  logic [1:0] rng;
  logic [7:0] code1, code2;
  logic [16:0] cur1, cur2;
  logic [23:0] rd;
  int err_count = 0;
  int cmp_count = 0;
  int oe_cycles = 0;
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin err_count++; \
  $display("[ERR] %0t act=%0h exp=%0h", $time, (act), (exp)); end end
  frontend_gain_led_config_regs frontend_gain_led_config_regs_inst (.clock_i(clock_i), .nrst_i(nrst_i),
    .serial_clk_i(sclk), .serial_select_n_i(sel_n), .serial_data_i(sdi), .read_enable_i(rd_en),
    .tx_ref_i(tx_ref), .serial_data_o(sdo), .serial_data_oe_o(sdo_oe), .ambient_cancel_current_o(amb),
    .filter_corner_select_o(filt), .second_stage_enable_b_o(en_b), .second_stage_gain_b_o(gain),
    .feedback_cap_select_o(cap), .feedback_res_select_o(res), .drive_fullscale_range_o(rng),
    .first_emitter_drive_code_o(code1), .second_emitter_drive_code_o(code2),
    .first_emitter_current_ua_o(cur1), .second_emitter_current_ua_o(cur2));
  serial_host_model serial_host_model_inst (.clock_i(clock_i), .data_i(sdo), .serial_clk_o(sclk),
    .select_n_o(sel_n), .data_o(sdi), .read_enable_o(rd_en));
  // Counts clock edges with the read driver enabled, to judge each frame
  always @(posedge clock_i) begin
    if (sdo_oe === 1'b1) begin
      oe_cycles++;
    end
  end
  // Full-scale current per range and reference; unusable pairs and transmit off give zero
  function automatic logic [16:0] exp_ua(input logic [1:0] rg, input logic [1:0] rf, input logic [7:0] c);
    int fs;
    fs = 0;
    if (rg == 2'h1) begin
      fs = (rf == 2'h0) ? 25 : (rf == 2'h1) ? 50 : (rf == 2'h3) ? 75 : 100;
    end else if (rg != 2'h3 && rf == 2'h0) begin
      fs = 50;
    end else if (rg != 2'h3 && rf == 2'h1) begin
      fs = 100;
    end
    return 17'((int'(c) * fs * 1000) / 256);
  endfunction
  // Driver stays on for the 24 data bits of a read, four clocks each, and never in a write
  task automatic xfer(input logic [7:0] a, input logic r, input logic [23:0] w);
    oe_cycles = 0;
    serial_host_model_inst.frame(a, r, w, rd);
    `CHK(oe_cycles, r ? 96 : 0)
  endtask
  task automatic chk_rx(input logic [23:0] v);
    `CHK(amb, v[19:16])
    `CHK(en_b, v[14])
    `CHK(gain, v[10:8])
    `CHK(cap, v[7:3])
    `CHK({filt, res}, {v[15], v[2:0]})
    xfer(8'h21, 1'b1, 24'h000000);
    `CHK(rd, v)
  endtask
  task automatic chk_em(input logic [23:0] v);
    `CHK(rng, v[17:16])
    `CHK(code1, v[15:8])
    `CHK(code2, v[7:0])
    xfer(8'h22, 1'b1, 24'h000000);
    `CHK(rd, v)
  endtask
  task automatic t_reset();
    chk_rx(24'h000000);
    chk_em(24'h000000);
  endtask
  task automatic t_rx();
    xfer(8'h21, 1'b0, 24'h0A447D);
    chk_rx(24'h0A447D);
    xfer(8'h21, 1'b0, 24'h000383);
    chk_rx(24'h000383);
  endtask
  task automatic t_em();
    for (int r = 0; r < 4; r++) begin
      xfer(8'h22, 1'b0, {6'h00, 2'(r), 8'h80, 8'hFF});
      chk_em({6'h00, 2'(r), 8'h80, 8'hFF});
      for (int f = 0; f < 4; f++) begin
        tx_ref = 2'(f);
        repeat (3) @(posedge clock_i);
        #1;
        if (r == 1 && f == 2) `CHK({cur1, cur2}, {17'h0C350, 17'h18519})
        `CHK({cur1, cur2}, {exp_ua(2'(r), 2'(f), 8'h80), exp_ua(2'(r), 2'(f), 8'hFF)})
      end
    end
  endtask
  task automatic t_unmapped();
    xfer(8'h23, 1'b0, 24'h123456);
    xfer(8'h23, 1'b1, 24'h000000);
    `CHK(rd, 24'h000000)
    chk_rx(24'h000383);
    chk_em(24'h0380FF);
  endtask
  task automatic t_mid_reset();
    nrst_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    nrst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK({cur1, cur2}, 34'h000000000)
    t_reset();
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    repeat (16) @(posedge clock_i);
    #1;
    nrst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    t_reset();
    t_rx();
    t_em();
    t_unmapped();
    t_mid_reset();
    results();
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
